/* bench/srs_board_model.sv */
// board side model: supply rails, main reset wire and test strap
`timescale 1ns/100ps
module srs_board_model (
  // commands from the bench
  input  wire logic standby_up_i,
  input  wire logic main_up_i,
  input  wire logic ext_pull_i,
  input  wire logic strap_high_i,
  // device side of the main reset pin
  input  wire logic dev_rst_d_i,
  input  wire logic dev_rst_oe_i,
  // board wires
  output logic      standby_ok_o,
  output logic      main_ok_o,
  output logic      main_wire_o,
  output logic      strap_o
);
  assign standby_ok_o = standby_up_i;
  assign main_ok_o    = main_up_i;
  // pull-up holds the wire high once nobody pulls it low
  assign main_wire_o  = ((dev_rst_oe_i && !dev_rst_d_i) || ext_pull_i) ? 1'b0 : 1'b1;
  assign strap_o      = strap_high_i;
endmodule // srs_board_model

/* bench/testbench.sv */
// self-checking bench for the supply reset sequencer
`timescale 1ns/100ps
module testbench;
  import srs_pkg::*;
  localparam int unsigned H = 20;
  logic ref_clk_i = 1'b0;
  logic reset_i   = 1'b1;
  logic sb_up = 1'b0, mn_up = 1'b0, ext_pull = 1'b0, strap = 1'b0;
  logic duty  = 1'b0, inv = 1'b0;
  logic sb_ok, mn_ok, mn_wire, strap_pin;
  logic sb_n, rst_d, rst_oe, sense_n, pwm_lvl, pwm_oe, nand_md;
  int   fails   = 0;
  int   n_tests = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  srs_board_model board_u (.standby_up_i(sb_up), .main_up_i(mn_up), .ext_pull_i(ext_pull),
    .strap_high_i(strap), .dev_rst_d_i(rst_d), .dev_rst_oe_i(rst_oe),
    .standby_ok_o(sb_ok), .main_ok_o(mn_ok), .main_wire_o(mn_wire), .strap_o(strap_pin));

  srs_sequencer #(.HOLD_CYCLES(H)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .standby_supply_rail_ok_i(sb_ok), .main_supply_rail_ok_i(mn_ok),
    .standby_reset_out_n_o(sb_n), .main_reset_io_n_i(mn_wire), .main_reset_io_n_o(rst_d),
    .main_reset_io_oe_o(rst_oe), .main_reset_sense_n_o(sense_n), .fan_duty_i(duty),
    .pwm_invert_i(inv), .fan_pwm_level_o(pwm_lvl), .fan_pwm_oe_o(pwm_oe),
    .nand_test_strap_i(strap_pin), .nand_tree_mode_o(nand_md));

  task automatic chk(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %s expected %b seen %b", nm, exp, got);
      fails++;
    end
  endtask

  task automatic chk_n(input string nm, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      $display("FAIL %s expected %0d seen %0d", nm, exp, got);
      fails++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // counts cycles until the chosen reset output lets go
  task automatic meas(input bit main, input int exp, input string nm);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (n < 100 && (main ? rst_oe !== 1'b0 : sb_n !== 1'b1));
    chk_n(nm, exp, n);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset;
    cyc(12);
    chk("pwm in reset", 1'b1, pwm_lvl);
    chk("pwm oe in reset", 1'b0, pwm_oe);
    chk("main data", 1'b0, rst_d);
    reset_i = 1'b0;
    cyc(5);
    chk("standby low rail", 1'b0, sb_n);
    chk("main low rail", 1'b1, rst_oe);
    chk("mode normal", 1'b0, nand_md);
  endtask

  task automatic t_power_up;
    sb_up = 1'b1;
    mn_up = 1'b1;
    meas(1'b0, H + 3, "standby hold");
    meas(1'b1, H + 1, "main after standby");
  endtask

  task automatic t_main_late;
    mn_up = 1'b0;
    cyc(3);
    chk("main dip", 1'b1, rst_oe);
    chk("standby kept", 1'b1, sb_n);
    cyc(5);
    mn_up = 1'b1;
    meas(1'b1, H + 3, "main hold");
  endtask

  task automatic t_dip;
    sb_up = 1'b0;
    cyc(4);
    chk("standby dip", 1'b0, sb_n);
    chk("main follows", 1'b1, rst_oe);
    sb_up = 1'b1;
    cyc(H / 2);
    sb_up = 1'b0;
    cyc(1);
    sb_up = 1'b1;
    meas(1'b0, H + 3, "standby restart");
    meas(1'b1, H + 1, "main restart");
  endtask

  task automatic t_sense;
    ext_pull = 1'b1;
    cyc(3);
    chk("sense low", 1'b0, sense_n);
    chk("oe untouched", 1'b0, rst_oe);
    chk("main data idle", 1'b0, rst_d);
    ext_pull = 1'b0;
    cyc(3);
    chk("sense high", 1'b1, sense_n);
  endtask

  task automatic t_pwm;
    for (int i = 0; i < 4; i++) begin
      duty = i[0];
      inv  = i[1];
      cyc(1);
      chk("pwm level", duty ^ inv, pwm_lvl);
      chk("pwm oe", !(duty ^ inv), pwm_oe);
    end
  endtask

  task automatic t_strap(input logic s);
    duty    = 1'b0;
    inv     = 1'b0;
    strap   = s;
    reset_i = 1'b1;
    cyc(12);
    reset_i = 1'b0;
    cyc(2);
    chk("nand mode", s, nand_md);
    chk("pwm forced", !s ? 1'b0 : 1'b1, pwm_lvl);
  endtask

  initial begin
    #(20ns * 2000);
    fails++;
    end_sim();
  end

  initial begin
    t_reset();
    t_power_up();
    t_main_late();
    t_dip();
    t_sense();
    t_pwm();
    t_strap(1'b1);
    t_strap(1'b0);
    end_sim();
  end
endmodule // testbench

/* inc/srs_hold_if.sv */
// hold timer link between the sequencer and its timers
`timescale 1ns/100ps
interface srs_hold_if;
  logic ok;
  logic done;

  modport timer (
    input  ok,
    output done
  );

  modport user (
    output ok,
    input  done
  );
endinterface

/* inc/srs_pkg.sv */
// constants shared by the supply reset sequencer
package srs_pkg;

  // ----------------------------------------------------------------
  // clock and hold timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned HOLD_MS     = 180;
  localparam int unsigned HOLD_CYCLES =
    32'((64'(HOLD_MS) * 64'(CLK_HZ)) / 64'd1000);

  // ----------------------------------------------------------------
  // reset and power-up values
  // ----------------------------------------------------------------
  localparam logic PWM_POWERUP_LEVEL = 1'b1;
  localparam logic RESET_ASSERTED_N  = 1'b0;
  localparam logic NAND_MODE_RESET   = 1'b0;

endpackage

/* src/srs_hold_timer.sv */
// counts a fixed hold interval while a rail stays good
`timescale 1ns/100ps
module srs_hold_timer #(
  parameter int unsigned HOLD = srs_pkg::HOLD_CYCLES
) (
  // clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   reset_i,
  // timer link
  srs_hold_if.timer   link
);
  import srs_pkg::*;

  localparam int unsigned W = $clog2(HOLD + 1);

  logic [W-1:0] count;

  // ----------------------------------------------------------------
  // hold counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !link.ok) begin
      count <= '0;
    end else if (count != W'(HOLD)) begin
      count <= count + W'(1);
    end
  end

  assign link.done = (count == W'(HOLD));

endmodule // srs_hold_timer

/* src/srs_sequencer.sv */
// supply reset sequencer: rail resets, fan pwm pin and test strap
`timescale 1ns/100ps
// Functional notes
// - standby reset stays low while the standby rail is below threshold.
// - standby reset is released only after the hold interval of good rail.
// - main reset stays low while the main rail is below threshold.
// - main reset is released only after the hold interval of good rail.
// - main reset released a hold interval after standby reset release.
// - main reset pin is also an active-low input, sensed by the device.
// - fan pwm pin is driven high at power-up.
// - a set invert control flips the fan pwm polarity; in nand tree mode the code ignores it and holds the pin high.
// - strap high at power-on puts the device into nand tree mode.
module srs_sequencer #(
  parameter int unsigned HOLD_CYCLES = srs_pkg::HOLD_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // rail comparators
  input  wire logic standby_supply_rail_ok_i,
  input  wire logic main_supply_rail_ok_i,
  // standby reset pin
  output logic      standby_reset_out_n_o,
  // main reset pin
  input  wire logic main_reset_io_n_i,
  output logic      main_reset_io_n_o,
  output logic      main_reset_io_oe_o,
  output logic      main_reset_sense_n_o,
  // fan pwm pin
  input  wire logic fan_duty_i,
  input  wire logic pwm_invert_i,
  output logic      fan_pwm_level_o,
  output logic      fan_pwm_oe_o,
  // test strap
  input  wire logic nand_test_strap_i,
  output logic      nand_tree_mode_o
);
  import srs_pkg::*;

  localparam int unsigned RUN_W = $clog2(HOLD_CYCLES + 1);

  logic stby_ok_s1;
  logic stby_ok_s;
  logic main_ok_s1;
  logic main_ok_s;
  logic pin_s1;
  logic pin_s;
  logic strap_s1;
  logic strap_s;
  logic strap_taken;
  logic next_fan_level;

  srs_hold_if stby_link ();
  srs_hold_if main_link ();

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    stby_ok_s1 <= standby_supply_rail_ok_i;
    stby_ok_s  <= stby_ok_s1;
    main_ok_s1 <= main_supply_rail_ok_i;
    main_ok_s  <= main_ok_s1;
    pin_s1     <= main_reset_io_n_i;
    pin_s      <= pin_s1;
    strap_s1   <= nand_test_strap_i;
    strap_s    <= strap_s1;
  end

  // ----------------------------------------------------------------
  // hold timers
  // ----------------------------------------------------------------
  assign stby_link.ok = stby_ok_s;
  assign main_link.ok = main_ok_s && standby_reset_out_n_o;

  srs_hold_timer #(
    .HOLD (HOLD_CYCLES)
  ) u_stby_timer (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .link      (stby_link)
  );

  srs_hold_timer #(
    .HOLD (HOLD_CYCLES)
  ) u_main_timer (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .link      (main_link)
  );

  // ----------------------------------------------------------------
  // standby reset output
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      standby_reset_out_n_o <= RESET_ASSERTED_N;
    end else begin
      standby_reset_out_n_o <= stby_ok_s && stby_link.done;
    end
  end

  // ----------------------------------------------------------------
  // main reset pin, open drain
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      main_reset_io_n_o  <= RESET_ASSERTED_N;
      main_reset_io_oe_o <= 1'b1;
    end else begin
      main_reset_io_n_o  <= RESET_ASSERTED_N;
      main_reset_io_oe_o <= !(main_link.ok && main_link.done);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      main_reset_sense_n_o <= RESET_ASSERTED_N;
    end else begin
      main_reset_sense_n_o <= pin_s;
    end
  end

  // ----------------------------------------------------------------
  // test strap capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      strap_taken      <= 1'b0;
      nand_tree_mode_o <= NAND_MODE_RESET;
    end else if (!strap_taken) begin
      strap_taken      <= 1'b1;
      nand_tree_mode_o <= strap_s;
    end
  end

  // ----------------------------------------------------------------
  // fan pwm pin, open drain
  // ----------------------------------------------------------------
  always_comb begin
    next_fan_level = PWM_POWERUP_LEVEL;
    if (!nand_tree_mode_o) begin
      next_fan_level = fan_duty_i ^ pwm_invert_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fan_pwm_level_o <= PWM_POWERUP_LEVEL;
      fan_pwm_oe_o    <= !PWM_POWERUP_LEVEL;
    end else begin
      fan_pwm_level_o <= next_fan_level;
      fan_pwm_oe_o    <= !next_fan_level;
    end
  end

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  logic [RUN_W-1:0] stby_run;
  logic [RUN_W-1:0] main_run;
  logic [RUN_W-1:0] rel_run;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !stby_ok_s) begin
      stby_run <= '0;
    end else if (stby_run != RUN_W'(HOLD_CYCLES)) begin
      stby_run <= stby_run + RUN_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !main_ok_s) begin
      main_run <= '0;
    end else if (main_run != RUN_W'(HOLD_CYCLES)) begin
      main_run <= main_run + RUN_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !standby_reset_out_n_o) begin
      rel_run <= '0;
    end else if (rel_run != RUN_W'(HOLD_CYCLES)) begin
      rel_run <= rel_run + RUN_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_stby_low_rail: assert property (!stby_ok_s |=> !standby_reset_out_n_o)
    else $error("standby reset released with rail low");
  a_stby_hold_time: assert property (
    $rose(standby_reset_out_n_o) |-> $past(stby_run) == RUN_W'(HOLD_CYCLES))
    else $error("standby reset released before hold interval");
  a_main_low_rail: assert property (!main_ok_s |=> main_reset_io_oe_o)
    else $error("main reset released with rail low");
  a_main_hold_time: assert property (
    $fell(main_reset_io_oe_o) |-> $past(main_run) == RUN_W'(HOLD_CYCLES))
    else $error("main reset released before hold interval");
  a_main_after_stby: assert property (
    $fell(main_reset_io_oe_o) |-> standby_reset_out_n_o
      && $past(rel_run) == RUN_W'(HOLD_CYCLES))
    else $error("main reset released too soon after standby");
  a_main_pin_sense: assert property (
    !main_reset_io_n_i [*3] |=> !main_reset_sense_n_o)
    else $error("main reset pin low not sensed");
  a_pwm_powerup_high: assert property (
    $fell(reset_i) |-> fan_pwm_level_o && !fan_pwm_oe_o)
    else $error("fan pwm not high at power-up");
  a_pwm_invert_pol: assert property (
    !nand_tree_mode_o |=> fan_pwm_level_o == ($past(fan_duty_i) ^ $past(pwm_invert_i))
      && fan_pwm_oe_o == !fan_pwm_level_o)
    else $error("fan pwm polarity wrong");
  a_nand_strap_take: assert property (
    !strap_taken |=> nand_tree_mode_o == $past(strap_s) ##1 $stable(nand_tree_mode_o))
    else $error("test strap not captured at power-on");
  a_stby_dip_restart: assert property (
    !stby_ok_s ##1 stby_ok_s |=> !standby_reset_out_n_o [*8])
    else $error("standby hold not restarted after rail dip");

  c_stby_release: cover property ($rose(standby_reset_out_n_o));
  c_main_release: cover property ($fell(main_reset_io_oe_o));
  c_nand_mode: cover property ($rose(nand_tree_mode_o));
  c_pwm_inverted: cover property (pwm_invert_i && !nand_tree_mode_o ##1 !fan_pwm_level_o);

endmodule // srs_sequencer
